// *** uic_pkg.sv ***
// Shared constants and types of the serial channel control block
package uic_pkg;
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_MASK   = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_FORMAT = 3'h3;
  localparam logic [2:0] ADDR_LSTAT  = 3'h5;
  localparam logic [2:0] ADDR_MSTAT  = 3'h6;
  localparam int MASK_RX    = 0;
  localparam int MASK_TX    = 1;
  localparam int MASK_LINE  = 2;
  localparam int MASK_MODEM = 3;
  localparam int QC_ENABLE  = 0;
  localparam int QC_RX_RST  = 1;
  localparam int QC_TX_RST  = 2;
  localparam int QC_DMA     = 3;
  localparam int LF_STOP    = 2;
  localparam int LF_PARITY  = 3;
  localparam int LF_EVEN    = 4;
  localparam int LF_DIVISOR = 7;
  localparam logic [3:0] MASK_RESET   = 4'h0;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET    = 8'h00;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [3:0] CODE_LINE  = 4'h6;
  localparam logic [3:0] CODE_TMO   = 4'hC;
  localparam logic [3:0] CODE_RX    = 4'h4;
  localparam logic [3:0] CODE_TX    = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  localparam logic [3:0] CODE_NONE  = 4'h1;
  localparam int TMO_CHARS = 4;
  localparam int TMO_BITS  = 12;
  typedef enum logic [5:0] {
    SRC_NONE  = 6'h01,
    SRC_MODEM = 6'h02,
    SRC_TX    = 6'h04,
    SRC_RX    = 6'h08,
    SRC_TMO   = 6'h10,
    SRC_LINE  = 6'h20
  } uic_src_t;
endpackage : uic_pkg

// *** uic_prio.sv ***
// Priority encoder of the interrupt sources
`timescale 1ns/1ps
`default_nettype none
module uic_prio (
  // Enabled pending sources
  input  wire logic            line_act,
  input  wire logic            tmo_act,
  input  wire logic            rx_act,
  input  wire logic            tx_act,
  input  wire logic            modem_act,
  // Selected source
  output var uic_pkg::uic_src_t src,
  output logic [3:0]           code
);
  always_comb begin
    if (line_act) src = uic_pkg::SRC_LINE;
    else if (tmo_act) src = uic_pkg::SRC_TMO;
    else if (rx_act) src = uic_pkg::SRC_RX;
    else if (tx_act) src = uic_pkg::SRC_TX;
    else if (modem_act) src = uic_pkg::SRC_MODEM;
    else src = uic_pkg::SRC_NONE;
  end

  // A six-bit vector can hold codes outside the enum
  always_comb begin
    unique case (src)
      uic_pkg::SRC_LINE:  code = uic_pkg::CODE_LINE;
      uic_pkg::SRC_TMO:   code = uic_pkg::CODE_TMO;
      uic_pkg::SRC_RX:    code = uic_pkg::CODE_RX;
      uic_pkg::SRC_TX:    code = uic_pkg::CODE_TX;
      uic_pkg::SRC_MODEM: code = uic_pkg::CODE_MODEM;
      default:            code = uic_pkg::CODE_NONE;
    endcase
  end
endmodule : uic_prio
`default_nettype wire

// *** uic_timeout.sv ***
// Receive time-out timer counted in bit times
`timescale 1ns/1ps
`default_nettype none
module uic_timeout #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Conditions
  input  wire logic       enable,
  input  wire logic       rx_nonempty,
  input  wire logic       activity,
  input  wire logic       bit_tick,
  input  wire logic       clear,
  // Character format
  input  wire logic [1:0] word_length,
  input  wire logic       extra_stop,
  input  wire logic       parity_enable,
  // Flag
  output logic            timeout
);
  if (CNT_W < 7) begin : g_bad_width
    $error("uic_timeout: CNT_W too small for the time-out limit");
  end

  logic [3:0]       char_bits;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_timeout;
  logic             hit;

  // Start, data, parity and stop; one and a half stop bits count as two
  always_comb begin
    char_bits = 4'h7 + {2'b00, word_length} + {3'b000, parity_enable} + {3'b000, extra_stop};
    limit = CNT_W'(uic_pkg::TMO_CHARS * int'(char_bits) + uic_pkg::TMO_BITS);
    hit = enable && rx_nonempty && !activity && (cnt == limit);
    if (!enable || !rx_nonempty || activity) next_cnt = '0;
    else if (bit_tick && cnt != limit) next_cnt = cnt + CNT_W'(1);
    else next_cnt = cnt;
    next_timeout = hit || (timeout && !clear);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt     <= '0;
      timeout <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      timeout <= next_timeout;
    end
  end

  a_timeout_hit: assert property (@(posedge sys_clk) disable iff (!rstn)
    hit |=> timeout)
    else $error("time-out not flagged at limit");
endmodule : uic_timeout
`default_nettype wire

// *** uic_ctrl.sv ***
// Interrupt, queue and line format control of one serial channel
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W      = $clog2(FIFO_DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [2:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [7:0]            rdata,
  // Receive path status
  input  wire logic [7:0]       rx_data,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic             rx_loaded,
  input  wire logic             rx_overrun,
  input  wire logic [2:0]       rx_head_error,
  input  wire logic             rx_fifo_error,
  input  wire logic             bit_tick,
  // Transmit path status
  input  wire logic             tx_empty,
  input  wire logic             tx_shifter_empty,
  input  wire logic             tx_full,
  // Modem status from outside
  input  wire logic [7:0]       modem_status,
  // Transmit data and strobes to the data paths
  output logic [7:0]            tx_data,
  output logic                  tx_write,
  output logic                  rx_read,
  output logic                  modem_status_read,
  output logic                  rx_fifo_reset,
  output logic                  tx_fifo_reset,
  // Configuration
  output logic                  fifo_enable,
  output logic                  dma_mode,
  output logic [LVL_W-1:0]      rx_trigger_level,
  output logic [1:0]            word_length,
  output logic                  extra_stop,
  output logic                  parity_enable,
  output logic                  even_parity,
  output logic                  stick_parity,
  output logic                  send_break,
  output logic                  divisor_select,
  output logic [15:0]           divisor,
  // Interrupt and ready pins
  output logic                  irq,
  output logic                  transmit_ready_pin_n,
  output logic                  receive_ready_pin_n
);
  if (FIFO_DEPTH < 14 || LVL_W != $clog2(FIFO_DEPTH + 1)) begin : g_bad_param
    $error("uic_ctrl: FIFO_DEPTH below 14 or LVL_W inconsistent");
  end

  // Register state
  logic [3:0]       mask;
  logic [7:0]       line_format;
  logic [7:0]       div_lo;
  logic [7:0]       div_hi;
  logic             fifo_en;
  logic             dma;
  logic [LVL_W-1:0] trig;
  logic [3:0]       next_mask;
  logic [7:0]       next_line_format;
  logic [7:0]       next_div_lo;
  logic [7:0]       next_div_hi;
  logic             next_fifo_en;
  logic             next_dma;
  logic [LVL_W-1:0] next_trig;
  logic             next_rx_rst;
  logic             next_tx_rst;
  logic [7:0]       next_rdata;
  logic [7:0]       next_tx_data;

  // Interrupt state
  logic             tx_pend;
  logic             line_pend;
  logic             overrun;
  logic             tx_prev;
  logic             err_prev;
  logic             next_tx_pend;
  logic             next_line_pend;
  logic             next_overrun;
  logic             next_irq;
  logic             next_tx_pin_n;
  logic             next_rx_pin_n;

  // Decodes and sources
  logic             div_sel;
  logic             wr_hold;
  logic             wr_mask;
  logic             wr_dll;
  logic             wr_dlm;
  logic             wr_queue;
  logic             wr_format;
  logic             rd_hold;
  logic             rd_status;
  logic             rd_lstat;
  logic             rd_mstat;
  logic             rx_nonempty;
  logic             rx_hit;
  logic             timeout;
  logic             tx_set;
  logic             tx_clr;
  logic             line_set;
  logic             modem_pend;
  uic_pkg::uic_src_t src;
  logic [3:0]       code;

  always_comb begin
    div_sel   = line_format[uic_pkg::LF_DIVISOR];
    wr_hold   = wr && addr == uic_pkg::ADDR_DATA && !div_sel;
    wr_dll    = wr && addr == uic_pkg::ADDR_DATA && div_sel;
    wr_mask   = wr && addr == uic_pkg::ADDR_MASK && !div_sel;
    wr_dlm    = wr && addr == uic_pkg::ADDR_MASK && div_sel;
    wr_queue  = wr && addr == uic_pkg::ADDR_STATUS;
    wr_format = wr && addr == uic_pkg::ADDR_FORMAT;
    rd_hold   = rd && addr == uic_pkg::ADDR_DATA && !div_sel;
    rd_status = rd && addr == uic_pkg::ADDR_STATUS;
    rd_lstat  = rd && addr == uic_pkg::ADDR_LSTAT;
    rd_mstat  = rd && addr == uic_pkg::ADDR_MSTAT;
  end

  // Receive fill against trigger; in non-FIFO mode any held character counts
  always_comb begin
    rx_nonempty = rx_level != '0;
    rx_hit = fifo_en ? (rx_level >= trig) : rx_nonempty;
    modem_pend = |modem_status[3:0];
  end

  uic_timeout #(
    .CNT_W         (7)
  ) u_timeout (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .enable        (fifo_en),
    .rx_nonempty   (rx_nonempty),
    .activity      (rx_loaded || rd_hold),
    .bit_tick      (bit_tick),
    .clear         (rd_hold),
    .word_length   (line_format[1:0]),
    .extra_stop    (line_format[uic_pkg::LF_STOP]),
    .parity_enable (line_format[uic_pkg::LF_PARITY]),
    .timeout       (timeout)
  );

  // Sources gated by the mask, re-evaluated every clock
  uic_prio u_prio (
    .line_act      (mask[uic_pkg::MASK_LINE] && line_pend),
    .tmo_act       (mask[uic_pkg::MASK_RX] && timeout),
    .rx_act        (mask[uic_pkg::MASK_RX] && rx_hit),
    .tx_act        (mask[uic_pkg::MASK_TX] && tx_pend),
    .modem_act     (mask[uic_pkg::MASK_MODEM] && modem_pend),
    .src           (src),
    .code          (code)
  );

  // Register writes and read data
  always_comb begin
    next_mask        = mask;
    next_line_format = line_format;
    next_div_lo      = div_lo;
    next_div_hi      = div_hi;
    next_fifo_en     = fifo_en;
    next_dma         = dma;
    next_trig        = trig;
    next_rx_rst      = 1'b0;
    next_tx_rst      = 1'b0;
    next_tx_data     = tx_data;
    next_rdata       = 8'h00;
    if (wr_hold) next_tx_data = wdata;
    if (wr_mask) next_mask = wdata[3:0];
    if (wr_dll) next_div_lo = wdata;
    if (wr_dlm) next_div_hi = wdata;
    if (wr_format) next_line_format = wdata;
    if (wr_queue) begin
      next_fifo_en = wdata[uic_pkg::QC_ENABLE];
      if (wdata[uic_pkg::QC_ENABLE]) begin
        next_rx_rst = wdata[uic_pkg::QC_RX_RST];
        next_tx_rst = wdata[uic_pkg::QC_TX_RST];
        next_dma    = wdata[uic_pkg::QC_DMA];
        unique case (wdata[7:6])
          2'b00: next_trig = LVL_W'(uic_pkg::TRIG_L0);
          2'b01: next_trig = LVL_W'(uic_pkg::TRIG_L1);
          2'b10: next_trig = LVL_W'(uic_pkg::TRIG_L2);
          2'b11: next_trig = LVL_W'(uic_pkg::TRIG_L3);
        endcase
      end
    end
    if (rd) begin
      unique case (addr)
        uic_pkg::ADDR_DATA:   next_rdata = div_sel ? div_lo : rx_data;
        uic_pkg::ADDR_MASK:   next_rdata = div_sel ? div_hi : {4'h0, mask};
        uic_pkg::ADDR_STATUS: next_rdata = {fifo_en, fifo_en, 2'b00, code};
        uic_pkg::ADDR_FORMAT: next_rdata = line_format;
        uic_pkg::ADDR_LSTAT:  next_rdata = {rx_fifo_error,
                                            tx_empty && tx_shifter_empty,
                                            tx_empty, rx_head_error,
                                            overrun, rx_nonempty};
        uic_pkg::ADDR_MSTAT:  next_rdata = modem_status;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask          <= uic_pkg::MASK_RESET;
      line_format   <= uic_pkg::FORMAT_RESET;
      div_lo        <= uic_pkg::DIV_RESET;
      div_hi        <= uic_pkg::DIV_RESET;
      fifo_en       <= 1'b0;
      dma           <= 1'b0;
      trig          <= LVL_W'(uic_pkg::TRIG_L0);
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      tx_data       <= 8'h00;
      rdata         <= 8'h00;
    end else begin
      mask          <= next_mask;
      line_format   <= next_line_format;
      div_lo        <= next_div_lo;
      div_hi        <= next_div_hi;
      fifo_en       <= next_fifo_en;
      dma           <= next_dma;
      trig          <= next_trig;
      rx_fifo_reset <= next_rx_rst;
      tx_fifo_reset <= next_tx_rst;
      tx_data       <= next_tx_data;
      rdata         <= next_rdata;
    end
  end

  // Interrupt sources; a set in the clearing cycle wins
  always_comb begin
    tx_set = (tx_empty && !tx_prev)
           || (wr_mask && wdata[uic_pkg::MASK_TX] && !mask[uic_pkg::MASK_TX] && tx_empty);
    tx_clr = wr_hold || (rd_status && src == uic_pkg::SRC_TX);
    next_tx_pend = tx_set || (tx_pend && !tx_clr);
    line_set = rx_overrun || (|rx_head_error && !err_prev);
    next_line_pend = line_set || (line_pend && !rd_lstat);
    next_overrun = rx_overrun || (overrun && !rd_lstat);
    next_irq = src != uic_pkg::SRC_NONE;
    next_rx_pin_n = dma ? !(rx_hit || timeout) : !rx_nonempty;
    next_tx_pin_n = dma ? tx_full : !tx_empty;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_pend              <= 1'b0;
      line_pend            <= 1'b0;
      overrun              <= 1'b0;
      tx_prev              <= 1'b1;
      err_prev             <= 1'b0;
      irq                  <= 1'b0;
      tx_write             <= 1'b0;
      rx_read              <= 1'b0;
      modem_status_read    <= 1'b0;
      receive_ready_pin_n  <= 1'b1;
      transmit_ready_pin_n <= 1'b1;
    end else begin
      tx_pend              <= next_tx_pend;
      line_pend            <= next_line_pend;
      overrun              <= next_overrun;
      tx_prev              <= tx_empty;
      err_prev             <= |rx_head_error;
      irq                  <= next_irq;
      tx_write             <= wr_hold;
      rx_read              <= rd_hold;
      modem_status_read    <= rd_mstat;
      receive_ready_pin_n  <= next_rx_pin_n;
      transmit_ready_pin_n <= next_tx_pin_n;
    end
  end

  assign fifo_enable      = fifo_en;
  assign dma_mode         = dma;
  assign rx_trigger_level = trig;
  assign word_length      = line_format[1:0];
  assign extra_stop       = line_format[uic_pkg::LF_STOP];
  assign parity_enable    = line_format[uic_pkg::LF_PARITY];
  assign even_parity      = line_format[uic_pkg::LF_EVEN];
  assign stick_parity     = line_format[5];
  assign send_break       = line_format[6];
  assign divisor_select   = line_format[uic_pkg::LF_DIVISOR];
  assign divisor          = {div_hi, div_lo};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_status_idle_bit: assert property (
    rd_status |=> rdata[0] == ($past(src) == uic_pkg::SRC_NONE))
    else $error("status bit 0 does not match pending state");

  a_status_fifo_bits: assert property (
    rd_status |=> rdata[7:6] == {2{$past(fifo_en)}})
    else $error("status bits 7:6 do not mirror FIFO enable");

  a_line_first: assert property (
    (mask[uic_pkg::MASK_LINE] && line_pend) |-> code == uic_pkg::CODE_LINE)
    else $error("line status not reported first");

  a_rx_trigger_code: assert property (
    (fifo_en && mask[uic_pkg::MASK_RX] && rx_level >= trig && !line_pend && !timeout)
      |-> code == uic_pkg::CODE_RX)
    else $error("receive trigger not reported");

  a_tx_clear_write: assert property (
    (wr_hold && !tx_set) |=> !tx_pend)
    else $error("transmit ready not cleared by holding write");

  a_line_clear_read: assert property (
    (rd_lstat && !line_set) |=> !line_pend)
    else $error("line interrupt not cleared by line status read");

  a_tx_enable_now: assert property (
    (wr_mask && wdata[1] && !mask[1] && tx_empty) |=> tx_pend ##1 irq || !mask[1])
    else $error("enabling transmit ready while empty did not raise it");

  a_queue_ignored: assert property (
    (wr_queue && !wdata[0]) |=> !fifo_en && $stable(trig) && $stable(dma) && !rx_fifo_reset)
    else $error("queue control bits taken without enable");

  a_fifo_reset_pulse: assert property (
    (wr_queue && wdata[0] && wdata[1] && !$past(wr_queue)) |=> rx_fifo_reset ##1 !rx_fifo_reset)
    else $error("receive FIFO reset not a single pulse");

  a_ready_flag: assert property (
    rd_lstat |=> rdata[0] == ($past(rx_level) != '0))
    else $error("data ready flag wrong");

  a_irq_follow: assert property (
    (src != uic_pkg::SRC_NONE) |=> irq)
    else $error("interrupt output not raised for pending source");

  c_timeout_seen: cover property (timeout && mask[0] ##1 rd_hold);
  c_line_over_rx: cover property (line_pend && rx_hit && mask[2] && mask[0]);
  c_tx_status_clear: cover property (rd_status && src == uic_pkg::SRC_TX ##1 !tx_pend);
  c_trigger_14: cover property (fifo_en && trig == LVL_W'(uic_pkg::TRIG_L3) && rx_hit);
endmodule : uic_ctrl
`default_nettype wire

// *** uic_host.sv ***
// Host model that drives the register port of the control block
`timescale 1ns/1ps
`default_nettype none
module uic_host (
  // Clock and read data
  input  wire logic       sys_clk,
  input  wire logic [7:0] rdata,
  // Register port
  output logic [2:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr  = 3'h0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Writes set address and data together with a one-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data are taken in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : uic_host
`default_nettype wire

// *** tb_uic_ctrl.sv ***
// Self-checking bench of the serial channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_uic_ctrl;
  logic        sys_clk, rstn, bit_tick, rx_loaded, rx_overrun, rx_fifo_error, tx_full;
  logic        tx_empty, tx_shifter_empty, tx_write, rx_read, modem_status_read, irq;
  logic        rx_fifo_reset, tx_fifo_reset, fifo_enable, dma_mode, wr, rd;
  logic        extra_stop, parity_enable, even_parity, stick_parity, send_break, divisor_select;
  logic        transmit_ready_pin_n, receive_ready_pin_n;
  logic [1:0]  word_length;
  logic [2:0]  addr, rx_head_error;
  logic [4:0]  rx_level, rx_trigger_level;
  logic [7:0]  wdata, rdata, rx_data, modem_status, tx_data, d;
  logic [15:0] divisor;
  int          miscompares, checks;
  logic [4:0]  trg [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

  uic_ctrl #(.FIFO_DEPTH(16)) DUT (
    .sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .rx_data, .rx_level, .rx_loaded,
    .rx_overrun, .rx_head_error, .rx_fifo_error, .bit_tick, .tx_empty, .tx_shifter_empty,
    .tx_full, .modem_status, .tx_data, .tx_write, .rx_read, .modem_status_read,
    .rx_fifo_reset, .tx_fifo_reset, .fifo_enable, .dma_mode, .rx_trigger_level,
    .word_length, .extra_stop, .parity_enable, .even_parity, .stick_parity,
    .send_break, .divisor_select, .divisor, .irq, .transmit_ready_pin_n,
    .receive_ready_pin_n
  );
  uic_host HOST (.sys_clk, .rdata, .addr, .wdata, .wr, .rd);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    HOST.rd_reg(a, d);
    chk(16'(d), 16'(exp));
  endtask : rc
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cuts a hang short well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    wrap_up;
  end

  initial begin
    rstn             = 1'b0;
    bit_tick         = 1'b0;
    rx_loaded        = 1'b0;
    rx_overrun       = 1'b0;
    rx_fifo_error    = 1'b0;
    tx_full          = 1'b0;
    tx_empty         = 1'b1;
    tx_shifter_empty = 1'b1;
    rx_head_error    = 3'h0;
    rx_level         = 5'h00;
    rx_data          = 8'hA5;
    modem_status     = 8'h00;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    rc(3'h2, 8'h01);
    rc(3'h3, 8'h00);
    rc(3'h1, 8'h00);
    HOST.wr_reg(3'h3, 8'h7F);
    rc(3'h3, 8'h7F);
    chk(16'({word_length, extra_stop, parity_enable, even_parity}), 16'h1F);
    chk(16'({stick_parity, send_break}), 16'h3);
    HOST.wr_reg(3'h3, 8'h83);
    chk(16'(divisor_select), 16'h1);
    HOST.wr_reg(3'h0, 8'h34);
    HOST.wr_reg(3'h1, 8'h12);
    chk(divisor, 16'h1234);
    HOST.wr_reg(3'h3, 8'h03);
    HOST.wr_reg(3'h2, 8'h06);
    chk(16'({fifo_enable, rx_fifo_reset, tx_fifo_reset}), 16'h0);
    HOST.wr_reg(3'h2, 8'h0F);
    chk(16'({fifo_enable, rx_fifo_reset, tx_fifo_reset, dma_mode}), 16'hF);
    @(posedge sys_clk);
    #1;
    chk(16'({rx_fifo_reset, tx_fifo_reset}), 16'h0);
    for (int i = 0; i < 4; i++) begin
      HOST.wr_reg(3'h2, {i[1:0], 6'h01});
      chk(16'(rx_trigger_level), 16'(trg[i]));
      rc(3'h2, 8'hC1);
    end
    HOST.wr_reg(3'h2, 8'h41);
    modem_status <= 8'h01;
    HOST.wr_reg(3'h1, 8'h08);
    rc(3'h2, 8'hC0);
    chk(16'(irq), 16'h1);
    rc(3'h6, 8'h01);
    chk(16'(modem_status_read), 16'h1);
    modem_status <= 8'h00;
    rc(3'h2, 8'hC1);
    HOST.wr_reg(3'h1, 8'h02);
    rc(3'h2, 8'hC2);
    rc(3'h2, 8'hC1);
    tx_empty <= 1'b0;
    @(posedge sys_clk);
    tx_empty <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'(irq), 16'h1);
    HOST.wr_reg(3'h0, 8'h5A);
    chk(16'({tx_write, tx_data}), 16'h15A);
    rc(3'h2, 8'hC1);
    HOST.wr_reg(3'h1, 8'h05);
    rx_level <= 5'h03;
    rc(3'h2, 8'hC1);
    chk(16'({transmit_ready_pin_n, receive_ready_pin_n}), 16'h0);
    HOST.wr_reg(3'h2, 8'h49);
    @(posedge sys_clk);
    #1;
    chk(16'({transmit_ready_pin_n, receive_ready_pin_n}), 16'h1);
    HOST.wr_reg(3'h2, 8'h41);
    rx_level <= 5'h04;
    rc(3'h2, 8'hC4);
    rx_overrun <= 1'b1;
    @(posedge sys_clk);
    rx_overrun <= 1'b0;
    rc(3'h2, 8'hC6);
    rc(3'h5, 8'h63);
    rc(3'h2, 8'hC4);
    rx_level <= 5'h03;
    rc(3'h2, 8'hC1);
    // Ten bit characters: the time-out lands after 52 bit ticks
    HOST.wr_reg(3'h1, 8'h01);
    rx_level  <= 5'h01;
    rx_loaded <= 1'b1;
    bit_tick  <= 1'b1;
    @(posedge sys_clk);
    rx_loaded <= 1'b0;
    repeat (49) @(posedge sys_clk);
    rc(3'h2, 8'hC1);
    rc(3'h2, 8'hC1);
    rc(3'h2, 8'hCC);
    rc(3'h0, 8'hA5);
    chk(16'(rx_read), 16'h1);
    rc(3'h2, 8'hC1);
    bit_tick <= 1'b0;
    HOST.wr_reg(3'h1, 8'h04);
    rx_head_error <= 3'h4;
    rc(3'h2, 8'hC6);
    rc(3'h5, 8'h71);
    rc(3'h2, 8'hC1);
    rx_head_error <= 3'h0;
    HOST.wr_reg(3'h1, 8'h00);
    rx_fifo_error    <= 1'b1;
    tx_shifter_empty <= 1'b0;
    rc(3'h5, 8'hA1);
    rx_level <= 5'h00;
    rc(3'h5, 8'hA0);
    wrap_up;
  end
endmodule : tb_uic_ctrl
`default_nettype wire
